// [core/pllbc_top.sv]
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Bus clock follows synth output when select set, else crystal halved.
// - Switchover finishes within 1.5 crystal plus 1.5 synth cycles after select changes.
// - Selected clock output finishes the old source's high phase, then is held low until the new source is joined.
// - Bandwidth bit only switches high driver; low driver always on.
// - Hardware does not block select while bandwidth bit is one.
// - Synth-on runs synth off the clock path; when clear, select refused.
// - Factory test bit exists; user-mode writes cannot clear it.
// - Two-bit speed field picks one of four synthesizer taps.
// - Reset clears select and bandwidth, sets synth-on, speed field 01.
// - Stop returns bus clock to crystal halved and turns synth off.
// - Interrupt wake restores setup with select cleared; other wake resets.
// - Synth parked on wide driver while off; on enable the high driver follows the bandwidth bit.
// - Feedback divides synth output by 128, 64, 32 or 16.
module pllbc_top
  import pllbc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,

  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,

  // Processor mode and stop handshakes
  input  wire logic        user_mode,
  input  wire logic        stop_enter,
  input  wire logic        stop_exit_irq,
  input  wire logic        stop_exit_other,

  // Source clocks, asynchronous to clk
  input  wire logic        crystal_input,
  input  wire logic        synth_output_clock,

  // Synthesizer control
  output logic             synth_enable,
  output logic             high_bw_drive_en,
  output logic             low_bw_drive_en,
  output logic      [1:0]  speed_select,
  output logic             synth_feedback_clock,

  // Bus clock
  output logic             bus_clock,
  output logic             switch_busy
);

  // ---------------------------------------------------------------
  // Source clock sampling
  // ---------------------------------------------------------------

  logic xtal_level;
  logic xtal_rise;
  logic synth_level;
  logic synth_rise;

  pllbc_pin_sync u_xtal_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (crystal_input),
    .level (xtal_level),
    .rise  (xtal_rise),
    .fall  ()
  );

  pllbc_pin_sync u_synth_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .pin   (synth_output_clock),
    .level (synth_level),
    .rise  (synth_rise),
    .fall  ()
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------

  pllbc_ctrl_t ctrl_reg;
  pllbc_ctrl_t ctrl_next;
  logic        in_stop_reg;
  logic        in_stop_next;
  logic        xtal_div_reg;
  pllbc_sw_t   sw_reg;
  pllbc_sw_t   sw_next;
  logic        src_reg;
  logic        src_next;
  logic        bus_clock_next;
  logic [31:0] rd_data_next;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------

  wire bus_req     = wb_cyc_i && wb_stb_i;
  // Write commits at the edge where the master samples ack high
  wire bus_commit  = bus_req && wb_ack_o;
  wire hit_ctrl    = (wb_adr_i == PLLBC_CTRL_OFFSET);
  wire hit_status  = (wb_adr_i == PLLBC_STATUS_OFFSET);
  wire ctrl_wr     = bus_commit && wb_we_i && hit_ctrl && wb_sel_i[0] && !in_stop_reg;
  wire [7:0] wr_byte = wb_dat_i[7:0];

  // ---------------------------------------------------------------
  // Control register write rules
  // ---------------------------------------------------------------

  wire wr_bcs = wr_byte[PLLBC_BCS_BIT];
  wire wr_bwc = wr_byte[PLLBC_BWC_BIT];
  wire wr_on  = wr_byte[PLLBC_ON_BIT];
  wire wr_tst = wr_byte[PLLBC_TST_BIT];
  wire [1:0] wr_ps = wr_byte[PLLBC_PS_HI:PLLBC_PS_LO];

  // Select may only be set while the synth was already running before this write;
  // the bandwidth bit plays no part in it.
  wire bcs_allowed = ctrl_reg.synth_on && wr_on;
  // User mode may set the test bit but never clear it
  wire tst_keep    = user_mode && ctrl_reg.osc_factory_test;

  pllbc_ctrl_t ctrl_written;
  assign ctrl_written.bus_clock_select  = wr_bcs && bcs_allowed;
  assign ctrl_written.bandwidth_control = wr_bwc;
  assign ctrl_written.synth_on          = wr_on;
  assign ctrl_written.osc_factory_test  = wr_tst || tst_keep;
  assign ctrl_written.speed_select      = wr_ps;

  // ---------------------------------------------------------------
  // Stop mode
  // ---------------------------------------------------------------

  wire stop_go   = stop_enter && !in_stop_reg;
  wire wake_irq  = in_stop_reg && stop_exit_irq;
  wire wake_othr = in_stop_reg && stop_exit_other && !stop_exit_irq;

  always_comb begin
    ctrl_next    = ctrl_reg;
    in_stop_next = in_stop_reg;
    if (stop_go) begin
      // Keep the setup for an interrupt wake; the bus drops to the crystal
      ctrl_next.bus_clock_select = 1'b0;
      in_stop_next               = 1'b1;
    end else if (wake_othr) begin
      ctrl_next    = PLLBC_CTRL_RST;
      in_stop_next = 1'b0;
    end else if (wake_irq) begin
      ctrl_next.bus_clock_select = 1'b0;
      in_stop_next               = 1'b0;
    end else if (ctrl_wr) begin
      ctrl_next = ctrl_written;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg    <= PLLBC_CTRL_RST;
      in_stop_reg <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      in_stop_reg <= in_stop_next;
    end
  end

  // ---------------------------------------------------------------
  // Synthesizer drive
  // ---------------------------------------------------------------

  // Synth runs only when on and not stopped; it stays off the clock path
  wire synth_run = ctrl_reg.synth_on && !in_stop_reg;
  // While off the loop is parked on the wide driver; on enable the high
  // driver follows the bandwidth bit from the same edge.
  wire high_bw   = ctrl_reg.bandwidth_control || !synth_run;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      synth_enable     <= 1'b0;
      high_bw_drive_en <= 1'b1;
      low_bw_drive_en  <= 1'b1;
      speed_select     <= PLLBC_PS_RST;
    end else begin
      synth_enable     <= synth_run;
      high_bw_drive_en <= high_bw;
      low_bw_drive_en  <= 1'b1;
      speed_select     <= ctrl_reg.speed_select;
    end
  end

  pllbc_fb_div u_fb_div (
    .clk          (clk),
    .rst_b        (rst_b),
    .enable       (synth_run),
    .synth_rise   (synth_rise),
    .speed_select (ctrl_reg.speed_select),
    .fb_clk       (synth_feedback_clock)
  );

  // ---------------------------------------------------------------
  // Crystal divided by two
  // ---------------------------------------------------------------

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      xtal_div_reg <= 1'b0;
    end else if (xtal_rise) begin
      xtal_div_reg <= ~xtal_div_reg;
    end
  end

  // ---------------------------------------------------------------
  // Glitch-free clock switch
  // ---------------------------------------------------------------

  // Target source: one is synth, zero is crystal halved. The synth is
  // never targeted while it is off, even if the bit were set.
  wire target    = ctrl_reg.bus_clock_select && synth_run;
  wire old_level = src_reg ? synth_level : xtal_div_reg;
  wire new_level = target ? synth_level : xtal_div_reg;

  // Old source is left only at its low phase and the new one joined only
  // at its low phase, so no shortened high pulse reaches the bus.
  always_comb begin
    sw_next        = sw_reg;
    src_next       = src_reg;
    bus_clock_next = 1'b0;
    unique case (sw_reg)
      PLLBC_SW_RUN: begin
        bus_clock_next = old_level;
        if (target != src_reg) begin
          sw_next = PLLBC_SW_DROP;
        end
      end
      PLLBC_SW_DROP: begin
        bus_clock_next = old_level;
        if (!old_level) begin
          bus_clock_next = 1'b0;
          sw_next        = PLLBC_SW_ARM;
        end
      end
      PLLBC_SW_ARM: begin
        bus_clock_next = 1'b0;
        if (!new_level) begin
          src_next = target;
          sw_next  = PLLBC_SW_RUN;
        end
      end
      default: begin
        sw_next  = PLLBC_SW_ARM;
        src_next = src_reg;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_reg      <= PLLBC_SW_RUN;
      src_reg     <= 1'b0;
      bus_clock   <= 1'b0;
      switch_busy <= 1'b0;
    end else begin
      sw_reg      <= sw_next;
      src_reg     <= src_next;
      bus_clock   <= bus_clock_next;
      switch_busy <= (sw_next != PLLBC_SW_RUN);
    end
  end

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------

  function automatic logic [7:0] pack_ctrl(input pllbc_ctrl_t c);
    logic [7:0] b;
    b                           = 8'h00;
    b[PLLBC_BCS_BIT]            = c.bus_clock_select;
    b[PLLBC_BWC_BIT]            = c.bandwidth_control;
    b[PLLBC_ON_BIT]             = c.synth_on;
    b[PLLBC_TST_BIT]            = c.osc_factory_test;
    b[PLLBC_PS_HI:PLLBC_PS_LO]  = c.speed_select;
    return b;
  endfunction

  wire [7:0] status_byte = {3'h0,
                            bus_clock,
                            target,
                            in_stop_reg,
                            switch_busy,
                            src_reg};

  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_data_next[7:0] = pack_ctrl(ctrl_reg);
    end else if (hit_status) begin
      rd_data_next[7:0] = status_byte;
    end
  end

  // Answer one cycle after the request; unmapped reads return zero and
  // unmapped writes are acknowledged and dropped.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
      if (bus_req && !wb_ack_o && !wb_we_i) begin
        wb_dat_o <= rd_data_next;
      end
    end
  end

endmodule

// [core/pllbc_pkg.sv]
package pllbc_pkg;

  // Register map, byte addresses on the 32-bit bus
  localparam int         PLLBC_ADR_W          = 8;
  localparam logic [7:0] PLLBC_CTRL_OFFSET    = 8'h00;
  localparam logic [7:0] PLLBC_STATUS_OFFSET  = 8'h04;

  // Control register field positions
  localparam int PLLBC_BCS_BIT  = 7;
  localparam int PLLBC_BWC_BIT  = 6;
  localparam int PLLBC_ON_BIT   = 5;
  localparam int PLLBC_TST_BIT  = 4;
  localparam int PLLBC_PS_HI    = 1;
  localparam int PLLBC_PS_LO    = 0;

  // Control register reset values
  localparam logic       PLLBC_BCS_RST  = 1'b0;
  localparam logic       PLLBC_BWC_RST  = 1'b0;
  localparam logic       PLLBC_ON_RST   = 1'b1;
  localparam logic       PLLBC_TST_RST  = 1'b0;
  localparam logic [1:0] PLLBC_PS_RST   = 2'h1;

  // Status register field positions
  localparam int PLLBC_ST_SRC_BIT    = 0;
  localparam int PLLBC_ST_BUSY_BIT   = 1;
  localparam int PLLBC_ST_STOP_BIT   = 2;
  localparam int PLLBC_ST_TARGET_BIT = 3;
  localparam int PLLBC_ST_CLK_BIT    = 4;

  // Feedback divider: half period in synth cycles for speed select 00
  localparam int         PLLBC_FB_CNT_W   = 7;
  localparam logic [6:0] PLLBC_FB_HALF_MAX = 7'h40;

  typedef struct packed {
    logic       bus_clock_select;
    logic       bandwidth_control;
    logic       synth_on;
    logic       osc_factory_test;
    logic [1:0] speed_select;
  } pllbc_ctrl_t;

  localparam pllbc_ctrl_t PLLBC_CTRL_RST = '{PLLBC_BCS_RST, PLLBC_BWC_RST, PLLBC_ON_RST,
                                             PLLBC_TST_RST, PLLBC_PS_RST};

  // Clock switch states; run -> drop -> arm change one bit each, arm -> run changes two
  typedef enum logic [1:0] {
    PLLBC_SW_RUN  = 2'h0,
    PLLBC_SW_DROP = 2'h1,
    PLLBC_SW_ARM  = 2'h3
  } pllbc_sw_t;

endpackage

// [core/pllbc_pin_sync.sv]
`timescale 1ns/1ps
module pllbc_pin_sync
  import pllbc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Asynchronous pin
  input  wire logic pin,
  // Filtered level and its edges
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic meta_reg;
  logic s2_reg;
  logic s3_reg;

  // A change counts only once stages two and three agree
  wire agree      = (s2_reg == s3_reg);
  wire level_next = agree ? s3_reg : level;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= 1'b0;
      s2_reg   <= 1'b0;
      s3_reg   <= 1'b0;
      level    <= 1'b0;
      rise     <= 1'b0;
      fall     <= 1'b0;
    end else begin
      meta_reg <= pin;
      s2_reg   <= meta_reg;
      s3_reg   <= s2_reg;
      level    <= level_next;
      rise     <= level_next & ~level;
      fall     <= ~level_next & level;
    end
  end

endmodule

// [core/pllbc_fb_div.sv]
`timescale 1ns/1ps
module pllbc_fb_div
  import pllbc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Synthesizer side
  input  wire logic       enable,
  input  wire logic       synth_rise,
  input  wire logic [1:0] speed_select,
  // Feedback to the phase detector
  output logic            fb_clk
);

  logic [PLLBC_FB_CNT_W-1:0] cnt_reg;

  // Half period 64, 32, 16 or 8 gives division by 128, 64, 32 or 16
  wire [PLLBC_FB_CNT_W-1:0] half     = PLLBC_FB_HALF_MAX >> speed_select;
  wire [PLLBC_FB_CNT_W-1:0] cnt_inc  = cnt_reg + 7'h01;
  wire                      half_hit = synth_rise && (cnt_inc >= half);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
      fb_clk  <= 1'b0;
    end else if (!enable) begin
      cnt_reg <= '0;
      fb_clk  <= 1'b0;
    end else if (half_hit) begin
      cnt_reg <= '0;
      fb_clk  <= ~fb_clk;
    end else if (synth_rise) begin
      cnt_reg <= cnt_inc;
    end
  end

endmodule

// [verif/pllbc_checker.sv]
`timescale 1ns/1ps
module pllbc_checker
  import pllbc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Stop and synthesizer control
  input wire logic        stop_enter,
  input wire logic        synth_enable,
  input wire logic        high_bw_drive_en,
  input wire logic        low_bw_drive_en,
  input wire logic        synth_feedback_clock,
  // Bus clock
  input wire logic        bus_clock,
  input wire logic        switch_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  chk_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("unused read bits not zero");
  chk_low_drive_on: assert property (low_bw_drive_en)
    else $error("low bandwidth driver disabled");
  chk_wide_start: assert property (!synth_enable && $past(!synth_enable) |-> high_bw_drive_en)
    else $error("high bandwidth driver off while synth is off");
  chk_stop_synth_off: assert property (stop_enter |-> ##[1:2] !synth_enable)
    else $error("synth still running after stop");
  chk_fb_idle: assert property ((!synth_enable) [*4] |-> !synth_feedback_clock)
    else $error("feedback clock runs while synth off");
  chk_switch_bound: assert property ($rose(switch_busy) |-> ##[1:60] !switch_busy)
    else $error("clock switchover too long");
  chk_hold_low: assert property (switch_busy && $past(switch_busy) |-> !$rose(bus_clock))
    else $error("bus clock rose during switchover");

  cover property ($rose(switch_busy));
  cover property (stop_enter);
  cover property (wb_ack_o && !$past(wb_ack_o));
endmodule

bind pllbc_top pllbc_checker u_chk (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stop_enter(stop_enter),
  .synth_enable(synth_enable), .high_bw_drive_en(high_bw_drive_en),
  .low_bw_drive_en(low_bw_drive_en), .synth_feedback_clock(synth_feedback_clock),
  .bus_clock(bus_clock), .switch_busy(switch_busy)
);

// [verif/pll_bus_clock_control_test.sv]
`timescale 1ns/1ps
module pll_bus_clock_control_test
  import pllbc_pkg::*;
;
  logic        clk, rst_b, cyc, stb, we, um, s_in, s_irq, s_oth;
  logic        xtal = 1'b0;
  logic        syn  = 1'b0;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rd, dato;
  logic        ack, sen, hbw, lbw, fb, bclk, busy;
  logic [1:0]  spd;
  int          err_total = 0;
  int          n_tests   = 0;
  int          xc = 0;
  int          sc = 0;
  int          srise = 0;

  pllbc_top uut (
    .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack),
    .user_mode(um), .stop_enter(s_in), .stop_exit_irq(s_irq), .stop_exit_other(s_oth),
    .crystal_input(xtal), .synth_output_clock(syn), .synth_enable(sen),
    .high_bw_drive_en(hbw), .low_bw_drive_en(lbw), .speed_select(spd),
    .synth_feedback_clock(fb), .bus_clock(bclk), .switch_busy(busy)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Crystal period 10 clk, synth period 6 clk; srise counts synth rising edges
  always @(posedge clk) begin
    xc <= (xc == 4) ? 0 : xc + 1;
    sc <= (sc == 2) ? 0 : sc + 1;
    if (xc == 4) xtal <= ~xtal;
    if (sc == 2) syn <= ~syn;
    if (sc == 2 && !syn) srise <= srise + 1;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    // No cycle count is assumed here; the watchdog ends a hung wait
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  // Bus clock rising edges in 240 clk; the replica jitters by one sample
  task automatic rate(input int lo, input int hi);
    int c;
    logic p;
    c = 0;
    p = bclk;
    repeat (240) begin
      @(posedge clk);
      if (bclk === 1'b1 && p === 1'b0) c++;
      p = bclk;
    end
    check(32'(c >= lo && c <= hi), 32'h1);
  endtask

  task automatic fb_rise();
    int n;
    logic p;
    n = 0;
    do begin
      p = fb;
      @(posedge clk);
      n++;
    end while (!(fb === 1'b1 && p === 1'b0) && n < 3000);
    if (n >= 3000) err_total++;
  endtask

  task automatic pulse(input int w);
    s_in <= (w == 0);
    s_irq <= (w == 1);
    s_oth <= (w == 2);
    @(posedge clk);
    {s_in, s_irq, s_oth} <= 3'h0;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_reset();
    rdc(PLLBC_CTRL_OFFSET, 32'h21);
    check(32'(spd), 32'h1);
    check(32'({lbw, hbw, sen}), 32'h5);
    rdc(8'h08, 32'h0);
  endtask

  task automatic t_select();
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h80);
    rdc(PLLBC_CTRL_OFFSET, 32'h0);
    repeat (4) @(posedge clk);
    check(32'({sen, hbw}), 32'h1);
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h21);
    // Settling wait before select; bandwidth is set high in the same write on purpose to show it is not blocked
    repeat (20) @(posedge clk);
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'he1);
    rdc(PLLBC_CTRL_OFFSET, 32'he1);
    check(32'(hbw), 32'h1);
    repeat (80) @(posedge clk);
    bus(1'b0, PLLBC_STATUS_OFFSET, 32'h0);
    check(rd & 32'hf, 32'h9);
    rate(38, 41);
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h21);
    repeat (80) @(posedge clk);
    bus(1'b0, PLLBC_STATUS_OFFSET, 32'h0);
    check(rd & 32'hf, 32'h0);
    rate(11, 13);
  endtask

  task automatic t_test_bit();
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'hfe);
    rdc(PLLBC_CTRL_OFFSET, 32'hf2);
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h73);
    um <= 1'b1;
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h21);
    rdc(PLLBC_CTRL_OFFSET, 32'h31);
    um <= 1'b0;
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h21);
    rdc(PLLBC_CTRL_OFFSET, 32'h21);
  endtask

  task automatic t_speed();
    int base;
    for (int k = 0; k < 4; k++) begin
      // Tap change with select clear and synth off first
      bus(1'b1, PLLBC_CTRL_OFFSET, 32'(k));
      bus(1'b1, PLLBC_CTRL_OFFSET, 32'h20 | 32'(k));
      // Speed output is registered one edge behind the control register
      repeat (2) @(posedge clk);
      check(32'(spd), 32'(k));
      fb_rise();
      fb_rise();
      base = srise;
      fb_rise();
      check(32'(srise - base), 32'(128 >> k));
    end
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h21);
  endtask

  task automatic t_stop();
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h62);
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'he2);
    repeat (80) @(posedge clk);
    pulse(0);
    check(32'(sen), 32'h0);
    // Writes in stop are dropped, so the wake must restore the old setup
    bus(1'b1, PLLBC_CTRL_OFFSET, 32'h0);
    repeat (80) @(posedge clk);
    bus(1'b0, PLLBC_STATUS_OFFSET, 32'h0);
    check(rd & 32'h5, 32'h4);
    pulse(1);
    rdc(PLLBC_CTRL_OFFSET, 32'h62);
    check(32'(sen), 32'h1);
    pulse(0);
    pulse(2);
    rdc(PLLBC_CTRL_OFFSET, 32'h21);
  endtask

  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, um, s_in, s_irq, s_oth} = 7'h0;
    adr = 8'h0;
    sel = 4'h1;
    wdat = 32'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_select();
    t_test_bit();
    t_speed();
    t_stop();
    close_out();
  end

  initial begin
    repeat (40000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
